// ---- design/iefl_ctrl.sv ----
// Interrupt enable/flag logic with AXI4-Lite register access
// How it works
// (RULE_01) Flags set on event regardless of enables
// (RULE_02) Bit 7 is global request enable
// (RULE_03) Bit 6 gates all peripheral requests
// (RULE_04) Bits 5-3 enables, 2-0 flags
// (RULE_05) Core control mirrored at two addresses
// (RULE_06) All core control bits read/write
// (RULE_07) Peripheral enables at bits 6,3,2,1,0
// (RULE_08) Bit 6 gates conversion-done request
// (RULE_09) Bit 0 gates timer1 overflow request
// (RULE_10) Unimplemented peripheral bits read zero
// (RULE_11) Reset clears control and enable bits
// (RULE_12) Software clears flag before enabling
// (RULE_13) Peripheral flag register, one per source
// (RULE_14) Request equals global and gated sources
// (RULE_15) Flags stick until software writes zero
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
module iefl_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Source events, same clock domain, one-cycle pulses
  input wire iefl_pkg::iefl_events_t events,
  // Request to the core and summary interrupt
  output logic core_irq,
  output logic irq,
  // AXI4-Lite write address
  input wire logic [9:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read address
  input wire logic [9:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // AXI4-Lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  logic [7:0] core_ctrl, next_core_ctrl;
  logic [7:0] periph_en, next_periph_en;
  logic [7:0] periph_flag, next_periph_flag;
  logic [7:0] evt_status, next_evt_status;
  logic [7:0] evt_enable, next_evt_enable;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_idx, next_aw_idx;
  logic [7:0] wbyte, next_wbyte;
  logic wlane, next_wlane;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_write, core_hit, core_req, periph_req;
  logic [7:0] core_evt, periph_evt, rd_idx;
  logic [7:0] rd_val;
  logic rd_ok;

  // Event vectors laid out like the flag registers
  assign core_evt = {5'h00, events.timer0_ovf, events.ext_edge, events.pin_change};
  assign periph_evt = {1'b0, events.conv_done, 2'h0, events.serial, events.capcmp,
                       events.timer2_match, events.timer1_ovf};

  // Write takes both address and data in either order, then answers
  assign s_awready = !aw_held && !bvalid;
  assign s_wready = !w_held && !bvalid;

  // Address/data capture and register updates
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_wbyte = wbyte;
    next_wlane = wlane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_awvalid && s_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = s_awaddr[9:2];
    end
    if (s_wvalid && s_wready) begin
      next_w_held = 1'b1;
      next_wbyte = s_wdata[7:0];
      next_wlane = s_wstrb[0];
    end
    if (bvalid && s_bready) begin
      next_bvalid = 1'b0;
    end
    // Decided here, not by a separate assign, so the clear of the held flags cannot feed back on it
    do_write = next_aw_held && next_w_held && !bvalid;
    core_hit = (next_aw_idx == iefl_pkg::CORE_CTRL_IDX_LO) ||
               (next_aw_idx == iefl_pkg::CORE_CTRL_IDX_HI); // RULE_05
    next_core_ctrl = core_ctrl;
    next_periph_en = periph_en;
    next_periph_flag = periph_flag;
    next_evt_enable = evt_enable;
    next_evt_status = evt_status;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = iefl_pkg::RESP_OKAY;
      if (next_wlane) begin
        if (core_hit) begin
          next_core_ctrl = next_wbyte; // RULE_06 RULE_15
        end else if (next_aw_idx == iefl_pkg::PERIPH_EN_IDX) begin
          next_periph_en = next_wbyte & iefl_pkg::PERIPH_MASK; // RULE_07 RULE_10
        end else if (next_aw_idx == iefl_pkg::PERIPH_FLAG_IDX) begin
          next_periph_flag = next_wbyte & iefl_pkg::PERIPH_MASK; // RULE_13 RULE_15
        end else if (next_aw_idx == iefl_pkg::EVT_ENABLE_IDX) begin
          next_evt_enable = next_wbyte;
        end else if (next_aw_idx == iefl_pkg::EVT_CLEAR_IDX) begin
          next_evt_status = evt_status & ~next_wbyte;
        end else if (next_aw_idx != iefl_pkg::EVT_STATUS_IDX) begin
          next_bresp = iefl_pkg::RESP_SLVERR;
        end
      end
    end
    // Events set after any write so a set in the clear cycle wins
    next_core_ctrl = next_core_ctrl | core_evt; // RULE_01 RULE_04
    next_periph_flag = next_periph_flag | periph_evt; // RULE_01 RULE_13
    next_evt_status = next_evt_status | {core_evt[2:0], periph_evt[6], periph_evt[3:0]};
  end

  // Read channel: one read at a time, answer one cycle after acceptance
  assign s_arready = !rvalid;
  assign rd_idx = s_araddr[9:2];
  always_comb begin
    rd_ok = 1'b1;
    unique case (rd_idx)
      iefl_pkg::CORE_CTRL_IDX_LO, iefl_pkg::CORE_CTRL_IDX_HI: rd_val = core_ctrl; // RULE_05
      iefl_pkg::PERIPH_EN_IDX: rd_val = periph_en & iefl_pkg::PERIPH_MASK; // RULE_10
      iefl_pkg::PERIPH_FLAG_IDX: rd_val = periph_flag & iefl_pkg::PERIPH_MASK;
      iefl_pkg::EVT_STATUS_IDX: rd_val = evt_status;
      iefl_pkg::EVT_ENABLE_IDX: rd_val = evt_enable;
      iefl_pkg::EVT_CLEAR_IDX: rd_val = 8'h00; // Write-only
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rd_val};
      next_rresp = rd_ok ? iefl_pkg::RESP_OKAY : iefl_pkg::RESP_SLVERR;
    end
  end

  // State registers; all control bits clear at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_ctrl <= iefl_pkg::CORE_CTRL_RST; // RULE_11
      periph_en <= iefl_pkg::PERIPH_EN_RST; // RULE_11
      periph_flag <= iefl_pkg::PERIPH_FLAG_RST;
      evt_status <= iefl_pkg::EVT_RST;
      evt_enable <= iefl_pkg::EVT_RST;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h00;
      wbyte <= 8'h00;
      wlane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h00000000;
    end else begin
      core_ctrl <= next_core_ctrl;
      periph_en <= next_periph_en;
      periph_flag <= next_periph_flag;
      evt_status <= next_evt_status;
      evt_enable <= next_evt_enable;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Request combination; software should clear stale flags before enabling
  assign core_req = |(core_ctrl[iefl_pkg::CORE_EN_LSB +: 3] & core_ctrl[iefl_pkg::CORE_FLAG_LSB +: 3]); // RULE_04 RULE_12
  assign periph_req = core_ctrl[iefl_pkg::PERIPH_GRP_EN_BIT] &
                      (|(periph_en & periph_flag & iefl_pkg::PERIPH_MASK)); // RULE_03 RULE_08 RULE_09
  assign core_irq = core_ctrl[iefl_pkg::GLOBAL_EN_BIT] & (core_req | periph_req); // RULE_02 RULE_14
  assign irq = |(evt_status & evt_enable);

  assign s_bvalid = bvalid;
  assign s_bresp = bresp;
  assign s_rvalid = rvalid;
  assign s_rresp = rresp;
  assign s_rdata = rdata;

  // Checks
  property p_global_gate;
    @(posedge clk) disable iff (rst) !core_ctrl[7] |-> !core_irq;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("request while global enable low"); // RULE_02
  property p_periph_gate;
    @(posedge clk) disable iff (rst) (!core_ctrl[6] && !core_req) |-> !core_irq;
  endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("peripheral request without group enable"); // RULE_03
  property p_core_flag_set;
    @(posedge clk) disable iff (rst) events.timer0_ovf |=> core_ctrl[2];
  endproperty
  a_core_flag_set: assert property (p_core_flag_set) else $error("timer0 flag not set"); // RULE_01
  property p_conv_flag_set;
    @(posedge clk) disable iff (rst) events.conv_done |=> periph_flag[6];
  endproperty
  a_conv_flag_set: assert property (p_conv_flag_set) else $error("conversion flag not set"); // RULE_13
  property p_conv_req;
    @(posedge clk) disable iff (rst) (core_ctrl[7:6] == 2'h3 && periph_en[6] && periph_flag[6]) |-> core_irq;
  endproperty
  a_conv_req: assert property (p_conv_req) else $error("conversion request missing"); // RULE_08
  property p_timer1_count_req;
    @(posedge clk) disable iff (rst) (core_ctrl[7:6] == 2'h3 && periph_en[0] && periph_flag[0]) |-> core_irq;
  endproperty
  a_timer1_count_req: assert property (p_timer1_count_req) else $error("timer1 request missing"); // RULE_09
  property p_unimpl_zero;
    @(posedge clk) disable iff (rst) (periph_en & 8'hb0) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented enable bit set"); // RULE_10
  property p_flag_sticky;
    @(posedge clk) disable iff (rst) (periph_flag[1] && !do_write) |=> periph_flag[1];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware"); // RULE_15
  property p_read_answer;
    @(posedge clk) disable iff (rst) (s_arvalid && s_arready) |=> s_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered"); // RULE_06
  // Each source sets its flag the cycle after its pulse
  property p_ext_flag_set;
    @(posedge clk) disable iff (rst) events.ext_edge |=> core_ctrl[1];
  endproperty
  a_ext_flag_set: assert property (p_ext_flag_set) else $error("external edge flag not set"); // RULE_01
  property p_pin_flag_set;
    @(posedge clk) disable iff (rst) events.pin_change |=> core_ctrl[0];
  endproperty
  a_pin_flag_set: assert property (p_pin_flag_set) else $error("pin-change flag not set"); // RULE_04
  property p_timer1_count_flag_set;
    @(posedge clk) disable iff (rst) events.timer1_ovf |=> periph_flag[0];
  endproperty
  a_timer1_count_flag_set: assert property (p_timer1_count_flag_set) else $error("timer1 flag not set"); // RULE_13
  property p_status_set;
    @(posedge clk) disable iff (rst) events.timer0_ovf |=> evt_status[7];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status bit lost to a clear"); // RULE_01
  // Each core enable pairs with the flag three bits below it
  property p_timer0_pair;
    @(posedge clk) disable iff (rst) (core_ctrl[7] && core_ctrl[5] && core_ctrl[2]) |-> core_irq;
  endproperty
  a_timer0_pair: assert property (p_timer0_pair) else $error("timer0 request missing"); // RULE_04
  property p_ext_pair;
    @(posedge clk) disable iff (rst) (core_ctrl[7] && core_ctrl[4] && core_ctrl[1]) |-> core_irq;
  endproperty
  a_ext_pair: assert property (p_ext_pair) else $error("external edge request missing"); // RULE_04
  property p_pin_pair;
    @(posedge clk) disable iff (rst) (core_ctrl[7] && core_ctrl[3] && core_ctrl[0]) |-> core_irq;
  endproperty
  a_pin_pair: assert property (p_pin_pair) else $error("pin-change request missing"); // RULE_04
  property p_conv_only;
    @(posedge clk) disable iff (rst) (!core_req && periph_en == 8'h40 && !periph_flag[6]) |-> !core_irq;
  endproperty
  a_conv_only: assert property (p_conv_only) else $error("request from a disabled peripheral"); // RULE_08
  property p_core_sticky;
    @(posedge clk) disable iff (rst) (core_ctrl[2] && !do_write) |=> core_ctrl[2];
  endproperty
  a_core_sticky: assert property (p_core_sticky) else $error("core flag cleared by hardware"); // RULE_15
  property p_core_write;
    @(posedge clk) disable iff (rst) (do_write && core_hit && next_wlane && core_evt == 8'h00) |=>
      core_ctrl == $past(next_wbyte);
  endproperty
  a_core_write: assert property (p_core_write) else $error("core control write lost"); // RULE_06
  property p_write_answer;
    @(posedge clk) disable iff (rst) do_write |=> s_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered"); // RULE_06
  property p_unimpl_read;
    @(posedge clk) disable iff (rst) (s_arvalid && s_arready && rd_idx == iefl_pkg::PERIPH_EN_IDX) |=>
      (s_rdata[7] == 1'b0 && s_rdata[5:4] == 2'h0);
  endproperty
  a_unimpl_read: assert property (p_unimpl_read) else $error("unimplemented enable bit read as one"); // RULE_10
  c_core_irq: cover property (@(posedge clk) disable iff (rst) $rose(core_irq));
  c_periph_irq: cover property (@(posedge clk) disable iff (rst) periph_req && core_irq);
  c_write: cover property (@(posedge clk) disable iff (rst) s_bvalid && s_bready);
  c_status_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_read_err: cover property (@(posedge clk) disable iff (rst) s_rvalid && s_rresp == iefl_pkg::RESP_SLVERR);
endmodule

// ---- design/iefl_pkg.sv ----
// Package: register map, field positions and reset values of the interrupt enable/flag block
package iefl_pkg;
  // Register indices (printed offsets are indices, byte address is four times the index)
  localparam logic [7:0] CORE_CTRL_IDX_LO = 8'h0b;
  localparam logic [7:0] CORE_CTRL_IDX_HI = 8'h8b;
  localparam logic [7:0] PERIPH_EN_IDX = 8'h8c;
  localparam logic [7:0] PERIPH_FLAG_IDX = 8'h0c;
  localparam logic [7:0] EVT_STATUS_IDX = 8'hf0;
  localparam logic [7:0] EVT_CLEAR_IDX = 8'hf1;
  localparam logic [7:0] EVT_ENABLE_IDX = 8'hf2;
  // Core control bit positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_GRP_EN_BIT = 6;
  localparam int CORE_EN_LSB = 3;
  localparam int CORE_FLAG_LSB = 0;
  // Peripheral bit positions
  localparam int CONV_DONE_BIT = 6;
  localparam int SERIAL_BIT = 3;
  localparam int CAPCMP_BIT = 2;
  localparam int TIMER2_COUNT_BIT = 1;
  localparam int TIMER1_COUNT_BIT = 0;
  // Implemented peripheral bits
  localparam logic [7:0] PERIPH_MASK = 8'h4f;
  // Reset values; pin-change flag is unknown at power-on, zero chosen here
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_EN_RST = 8'h00;
  localparam logic [7:0] PERIPH_FLAG_RST = 8'h00;
  localparam logic [7:0] EVT_RST = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event pulses from the sources
  typedef struct packed {
    logic timer0_ovf;
    logic ext_edge;
    logic pin_change;
    logic conv_done;
    logic serial;
    logic capcmp;
    logic timer2_match;
    logic timer1_ovf;
  } iefl_events_t;
endpackage

// ---- test/iefl_src.sv ----
// Event source model: fires one-cycle event pulses on request
`timescale 1ns/100ps
module iefl_src (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the bench
  input wire logic go,
  input wire logic [7:0] fire,
  // Pulses toward the block
  output iefl_pkg::iefl_events_t events
);
  // Pulses last one cycle, as the sources do, so a held level never hides a missed set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      events <= '0;
    end else begin
      events <= go ? iefl_pkg::iefl_events_t'(fire) : '0;
    end
  end
endmodule

// ---- test/iefl_ctrl_test.sv ----
// Testbench of the interrupt enable/flag block
`timescale 1ns/100ps
module iefl_ctrl_test;
  localparam logic [9:0] A_CL = {iefl_pkg::CORE_CTRL_IDX_LO, 2'b00};
  localparam logic [9:0] A_CH = {iefl_pkg::CORE_CTRL_IDX_HI, 2'b00};
  localparam logic [9:0] A_PE = {iefl_pkg::PERIPH_EN_IDX, 2'b00};
  localparam logic [9:0] A_PF = {iefl_pkg::PERIPH_FLAG_IDX, 2'b00};
  localparam logic [9:0] A_ST = {iefl_pkg::EVT_STATUS_IDX, 2'b00};
  localparam logic [9:0] A_CR = {iefl_pkg::EVT_CLEAR_IDX, 2'b00};
  localparam logic [9:0] A_EN = {iefl_pkg::EVT_ENABLE_IDX, 2'b00};
  logic clk = 0, rst = 1, go = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0] fire = 0, r = 8'h4e;
  logic [9:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awr, wr_rdy, bv, arr, rv, core_irq, irq;
  iefl_pkg::iefl_events_t events;
  logic [33:0] q[$];
  logic [1:0] wq[$];
  logic [3:0] ws = 4'hf;
  logic [1:0] exp_b = iefl_pkg::RESP_OKAY;
  int mismatches = 0, n_tests = 0;
  iefl_src src (.clk(clk), .rst(rst), .go(go), .fire(fire), .events(events));
  iefl_ctrl dut (.clk(clk), .rst(rst), .events(events), .core_irq(core_irq), .irq(irq),
    .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(ws), .s_wvalid(wv),
    .s_wready(wr_rdy), .s_bresp(bresp), .s_bvalid(bv), .s_bready(bre), .s_araddr(ara), .s_arvalid(arv),
    .s_arready(arr), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rv), .s_rready(rre));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_rd(input logic [1:0] gr, input logic [31:0] gd, input logic [33:0] e);
    n_tests++;
    if ({gr, gd} !== e) fail($sformatf("read %h/%h want %h", gr, gd, e));
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) fail($sformatf("request line %b want %b", g, e));
  endtask
  task automatic chk_wr(input logic [1:0] g, input logic [1:0] e);
    n_tests++;
    if (g !== e) fail($sformatf("write response %h want %h", g, e));
  endtask
  // Write: address and data offered together, each dropped once taken; no cycle count assumed
  // Response ready stays high between transfers, so it is never dropped and raised in one step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    int i;
    wq.push_back(exp_b);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bre <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_rdy) wv <= 0;
      if (bv && bre) break;
    end
    if (i == 50) begin
      fail("write timeout");
      end_sim();
    end
  endtask
  // Read: the expectation is queued before the request goes out
  task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] rs);
    int i;
    q.push_back({rs, 24'h0, d});
    ara <= a;
    arv <= 1;
    rre <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv && rre) break;
    end
    if (i == 50) begin
      fail("read timeout");
      end_sim();
    end
  endtask
  task automatic pulse(input logic [7:0] v);
    fire <= v;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
  endtask
  // Read and write monitor takes the oldest note on each accepted answer
  always @(posedge clk) begin
    if (rv && rre) chk_rd(rresp, rdata, q.pop_front());
    if (bv && bre) chk_wr(bresp, wq.pop_front());
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(A_CL, iefl_pkg::CORE_CTRL_RST, iefl_pkg::RESP_OKAY);
    rd(A_PE, iefl_pkg::PERIPH_EN_RST, iefl_pkg::RESP_OKAY);
    $display("reset values done");
    wr(A_CL, 8'hff);
    rd(A_CH, 8'hff, iefl_pkg::RESP_OKAY);
    wr(A_CH, 8'h00);
    rd(A_CL, 8'h00, iefl_pkg::RESP_OKAY);
    wr(A_PE, 8'hff);
    rd(A_PE, iefl_pkg::PERIPH_MASK, iefl_pkg::RESP_OKAY);
    // A write with the low byte lane off must leave the register alone
    ws <= 4'he;
    wr(A_PE, 8'h00);
    ws <= 4'hf;
    rd(A_PE, iefl_pkg::PERIPH_MASK, iefl_pkg::RESP_OKAY);
    $display("register access done");
    r = lfsr(r);
    pulse(r);
    rd(A_CL, {5'h0, r[7:5]}, iefl_pkg::RESP_OKAY);
    rd(A_PF, {1'b0, r[4], 2'b0, r[3:0]}, iefl_pkg::RESP_OKAY);
    chk_bit(core_irq, 1'b0);
    // Stale flags cleared before the global and group enables go up; peripheral enables are already set
    wr(A_CL, 8'h00);
    wr(A_PF, 8'h00);
    pulse(8'hff);
    wr(A_CL, 8'h87);
    chk_bit(core_irq, 1'b0);
    wr(A_CL, 8'hc7);
    chk_bit(core_irq, 1'b1);
    wr(A_PE, 8'h40);
    chk_bit(core_irq, 1'b1);
    wr(A_PF, 8'h0f);
    chk_bit(core_irq, 1'b0);
    wr(A_PE, 8'h01);
    chk_bit(core_irq, 1'b1);
    wr(A_PF, 8'h00);
    chk_bit(core_irq, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(A_CL, 8'h80 | (8'h20 >> i) | (8'h04 >> i));
      chk_bit(core_irq, 1'b1);
      wr(A_CL, (8'h20 >> i) | (8'h04 >> i));
      chk_bit(core_irq, 1'b0);
    end
    // Timer0 enable with only the other two flags set must not request
    wr(A_CL, 8'ha3);
    chk_bit(core_irq, 1'b0);
    $display("request gating done");
    wr(A_EN, 8'hff);
    wr(A_CR, 8'hff);
    r = lfsr(r);
    pulse(r);
    rd(A_ST, r, iefl_pkg::RESP_OKAY);
    wr(A_ST, 8'h00);
    rd(A_ST, r, iefl_pkg::RESP_OKAY);
    rd(A_CR, 8'h00, iefl_pkg::RESP_OKAY);
    chk_bit(irq, 1'b1);
    wr(A_EN, 8'h00);
    chk_bit(irq, 1'b0);
    wr(A_CR, 8'hff);
    rd(A_ST, 8'h00, iefl_pkg::RESP_OKAY);
    rd(10'h100, 8'h00, iefl_pkg::RESP_SLVERR);
    exp_b = iefl_pkg::RESP_SLVERR;
    wr(10'h100, 8'h55);
    exp_b = iefl_pkg::RESP_OKAY;
    $display("status and unmapped done");
    // Reset in mid-run must clear what software set
    wr(A_CL, 8'hff);
    wr(A_PE, 8'hff);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(A_CL, iefl_pkg::CORE_CTRL_RST, iefl_pkg::RESP_OKAY);
    rd(A_PE, iefl_pkg::PERIPH_EN_RST, iefl_pkg::RESP_OKAY);
    chk_bit(core_irq, 1'b0);
    $display("mid-run reset done");
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
